// ===== core/ptp_event_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef PTP_EVENT_DEFS_SVH
`define PTP_EVENT_DEFS_SVH

// Register offsets (byte addresses)
`define OFS_GEN_CFG      12'h104
`define OFS_STS          12'h108
`define OFS_EN           12'h10C
`define OFS_TOP_EN       12'h180
`define OFS_TOP_STS      12'h184
`define OFS_MAN_CAP      12'h188
`define OFS_STAMP_POP    12'h18C
`define OFS_CAP_INFO_0   12'h190
`define OFS_CAP_INFO_1   12'h194
`define OFS_CAP_INFO_2   12'h198
// Target page: 0x140 + 0x10 per channel, addr[4] picks the channel
`define TGT_PAGE         7'h0A
`define SUB_TGT_SEC      2'h0
`define SUB_TGT_NS       2'h1
`define SUB_STEP_SEC     2'h2
`define SUB_STEP_NS      2'h3

// Field positions
`define GC_CLR_A_SEL     8
`define GC_CLR_A_EN      11
`define GC_CLR_B_SEL     12
`define GC_CLR_B_EN      15
`define STS_RX_LSB       8
`define STS_TX_LSB       12
`define STS_RISE_LSB     16
`define STS_FALL_LSB     24
`define POP_TX_LSB       4

// Masks and reset values
`define GEN_CFG_MASK     32'h0000FF03
`define STS_MASK         32'hFFFF7703
`define EN_MASK          32'hFFFF7703
`define REG_RESET        32'h00000000

// Counts and time
`define STAMP_MAX        3'h4
`define NS_PER_SEC       30'h3B9ACA00
`define CLK_PERIOD_NS    25
`define GPIO_MIN_NS      40
`define GPIO_FILT_CYC    ((`GPIO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GPIO_FILT_LAST   2'(`GPIO_FILT_CYC - 1)

`endif

// ===== core/ptp_event_pkg.sv
// Shared types of the timing event status block
package ptp_event_pkg;
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } ptp_time_t;

  typedef struct packed {
    logic [2:0] egress;
    logic [2:0] ingress;
  } stamp_evt_t;

  typedef enum logic {
    TGT_MODE_ADD    = 1'b0,
    TGT_MODE_RELOAD = 1'b1
  } tgt_mode_t;
endpackage

// ===== core/ptp_target_event_irq_status.sv
// Timing unit target reload/step logic and sticky event status register
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "ptp_event_defs.svh"
// Operation
// - Reload mode: compare event copies step values into the channel target
// - Add mode: compare event adds step values onto the channel target
// - Two select bits, B at bit 1, A at bit 0, reset to add
// - Writing one clears a status flag; zero leaves it alone
// - Enabled status flags are ORed into one cascade event bit
// - Flags set on events whatever their enable bits say
// - Interrupt only while cascade event and its top enable are set
// - Eight falling-edge capture flags in bits 31:24
// - Eight rising-edge capture flags in bits 23:16
// - Capture pins are edge sensitive, level must hold over 40 ns
// - Manual capture may set rising and falling capture flags
// - Three egress stamp flags in bits 14:12, set when stored
// - Three ingress stamp flags in bits 10:8, set when stored
// - Up to four stamps per port and direction, count readable
// - Timer flag A/B sets when clock reaches the channel target
// - Enabled GPIO active edge, filtered, clears the selected timer flag
module ptp_target_event_irq_status (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_b_i,
  input  wire logic [11:0]               reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [31:0]               reg_rdata_o,
  input  wire ptp_event_pkg::ptp_time_t  now_i,
  input  wire logic [7:0]                gpio_i,
  input  wire logic [7:0]                gpio_pol_i,
  input  wire ptp_event_pkg::stamp_evt_t stamp_evt_i,
  output logic                           irq_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0]              cfg_r, cfg_nxt;
  logic [31:0]              sts_r, sts_nxt;
  logic [31:0]              en_r, en_nxt;
  logic                     top_en_r, top_en_nxt;
  logic [31:0]              rdata_r, rdata_nxt;
  ptp_event_pkg::ptp_time_t tgt_r [2];
  ptp_event_pkg::ptp_time_t tgt_nxt [2];
  ptp_event_pkg::ptp_time_t step_r [2];
  ptp_event_pkg::ptp_time_t step_nxt [2];
  ptp_event_pkg::ptp_time_t add_val [2];
  logic [2:0]               tx_cnt_r [3];
  logic [2:0]               tx_cnt_nxt [3];
  logic [2:0]               rx_cnt_r [3];
  logic [2:0]               rx_cnt_nxt [3];
  logic [7:0]               sync1_r, sync2_r;
  logic [7:0]               filt_r, filt_nxt;
  logic [1:0]               fcnt_r [8];
  logic [1:0]               fcnt_nxt [8];
  logic [7:0]               rise_ev, fall_ev, act_edge;
  logic [7:0]               man_rise, man_fall;
  logic [2:0]               tx_store, rx_store, tx_pop, rx_pop;
  logic [1:0]               fire, clr_tim;
  logic [31:0]              sts_set, sts_clr;
  logic                     sts_wr, tgt_hit, cascade;
  logic [1:0]               tgt_ch, tgt_sub;

  function automatic ptp_event_pkg::ptp_time_t time_add(
    ptp_event_pkg::ptp_time_t a,
    ptp_event_pkg::ptp_time_t b);
    logic [30:0]              ns;
    ptp_event_pkg::ptp_time_t r;
    ns    = {1'b0, a.ns} + {1'b0, b.ns};
    r.sec = a.sec + b.sec;
    // Nanoseconds wrap at one second and carry into seconds
    if (ns >= {1'b0, `NS_PER_SEC}) begin
      ns    = ns - {1'b0, `NS_PER_SEC};
      r.sec = r.sec + 32'h1;
    end
    r.ns = ns[29:0];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign sts_wr  = reg_wr_i && (reg_addr_i == `OFS_STS);
  assign tgt_hit = (reg_addr_i[11:5] == `TGT_PAGE);
  assign tgt_ch  = {1'b0, reg_addr_i[4]};
  assign tgt_sub = reg_addr_i[3:2];
  assign man_rise = (reg_wr_i && reg_addr_i == `OFS_MAN_CAP) ?
                    reg_wdata_i[7:0] : 8'h00;
  assign man_fall = (reg_wr_i && reg_addr_i == `OFS_MAN_CAP) ?
                    reg_wdata_i[15:8] : 8'h00;
  assign rx_pop   = (reg_wr_i && reg_addr_i == `OFS_STAMP_POP) ?
                    reg_wdata_i[2:0] : 3'h0;
  assign tx_pop   = (reg_wr_i && reg_addr_i == `OFS_STAMP_POP) ?
                    reg_wdata_i[`POP_TX_LSB +: 3] : 3'h0;

  // ---------------------------------------------------------------
  // GPIO capture inputs
  // ---------------------------------------------------------------
  // A level change is taken only after it has held for the filter
  // count of two clocks, so pulses of 25 ns or less never reach the flags.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      filt_nxt[k] = filt_r[k];
      fcnt_nxt[k] = 2'h0;
      if (sync2_r[k] != filt_r[k]) begin
        if (fcnt_r[k] == `GPIO_FILT_LAST) begin
          filt_nxt[k] = sync2_r[k];
        end else begin
          fcnt_nxt[k] = fcnt_r[k] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      filt_r  <= 8'h00;
      for (int k = 0; k < 8; k++) begin
        fcnt_r[k] <= 2'h0;
      end
    end else begin
      sync1_r <= gpio_i;
      sync2_r <= sync1_r;
      filt_r  <= filt_nxt;
      for (int k = 0; k < 8; k++) begin
        fcnt_r[k] <= fcnt_nxt[k];
      end
    end
  end

  assign rise_ev  = filt_nxt & ~filt_r;
  assign fall_ev  = ~filt_nxt & filt_r;
  assign act_edge = (gpio_pol_i & rise_ev) | (~gpio_pol_i & fall_ev);
  assign clr_tim[0] = cfg_r[`GC_CLR_A_EN] &&
                      act_edge[cfg_r[`GC_CLR_A_SEL +: 3]];
  assign clr_tim[1] = cfg_r[`GC_CLR_B_EN] &&
                      act_edge[cfg_r[`GC_CLR_B_SEL +: 3]];

  // ---------------------------------------------------------------
  // Target channels
  // ---------------------------------------------------------------
  // Comparator fires every cycle the clock is at or past the target;
  // a zero step in add mode therefore keeps it firing.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      fire[c]    = {now_i.sec, now_i.ns} >=
                   {tgt_r[c].sec, tgt_r[c].ns};
      add_val[c] = time_add(tgt_r[c], step_r[c]);
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      tgt_nxt[c]  = tgt_r[c];
      step_nxt[c] = step_r[c];
      if (reg_wr_i && tgt_hit && tgt_ch == 2'(c)) begin
        unique case (tgt_sub)
          `SUB_TGT_SEC:  tgt_nxt[c].sec  = reg_wdata_i;
          `SUB_TGT_NS:   tgt_nxt[c].ns   = reg_wdata_i[29:0];
          `SUB_STEP_SEC: step_nxt[c].sec = reg_wdata_i;
          `SUB_STEP_NS:  step_nxt[c].ns  = reg_wdata_i[29:0];
        endcase
      end
      // Hardware update wins over a software write in the same cycle
      if (fire[c]) begin
        if (ptp_event_pkg::tgt_mode_t'(cfg_r[c]) ==
            ptp_event_pkg::TGT_MODE_RELOAD) begin
          tgt_nxt[c] = step_r[c];
        end else begin
          tgt_nxt[c] = add_val[c];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < 2; c++) begin
        tgt_r[c]  <= '0;
        step_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        tgt_r[c]  <= tgt_nxt[c];
        step_r[c] <= step_nxt[c];
      end
    end
  end

  // ---------------------------------------------------------------
  // Timestamp counts
  // ---------------------------------------------------------------
  // A stamp beyond the fourth is dropped and raises no flag.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      tx_store[p]   = stamp_evt_i.egress[p] && tx_cnt_r[p] < `STAMP_MAX;
      rx_store[p]   = stamp_evt_i.ingress[p] && rx_cnt_r[p] < `STAMP_MAX;
      tx_cnt_nxt[p] = tx_cnt_r[p];
      rx_cnt_nxt[p] = rx_cnt_r[p];
      if (tx_store[p] && !(tx_pop[p] && tx_cnt_r[p] != 3'h0)) begin
        tx_cnt_nxt[p] = tx_cnt_r[p] + 3'h1;
      end else if (!tx_store[p] && tx_pop[p] && tx_cnt_r[p] != 3'h0) begin
        tx_cnt_nxt[p] = tx_cnt_r[p] - 3'h1;
      end
      if (rx_store[p] && !(rx_pop[p] && rx_cnt_r[p] != 3'h0)) begin
        rx_cnt_nxt[p] = rx_cnt_r[p] + 3'h1;
      end else if (!rx_store[p] && rx_pop[p] && rx_cnt_r[p] != 3'h0) begin
        rx_cnt_nxt[p] = rx_cnt_r[p] - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < 3; p++) begin
        tx_cnt_r[p] <= 3'h0;
        rx_cnt_r[p] <= 3'h0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        tx_cnt_r[p] <= tx_cnt_nxt[p];
        rx_cnt_r[p] <= rx_cnt_nxt[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status, enables and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    sts_set = 32'h00000000;
    sts_set[`STS_FALL_LSB +: 8] = fall_ev | man_fall;
    sts_set[`STS_RISE_LSB +: 8] = rise_ev | man_rise;
    sts_set[`STS_TX_LSB +: 3]   = tx_store;
    sts_set[`STS_RX_LSB +: 3]   = rx_store;
    sts_set[1:0]                = fire;
    sts_clr = sts_wr ? reg_wdata_i : 32'h00000000;
    sts_clr[1:0] = sts_clr[1:0] | clr_tim;
    // Set is applied last so a simultaneous clear cannot lose it
    sts_nxt = ((sts_r & ~sts_clr) | sts_set) & `STS_MASK;
    cfg_nxt    = cfg_r;
    en_nxt     = en_r;
    top_en_nxt = top_en_r;
    if (reg_wr_i && reg_addr_i == `OFS_GEN_CFG) begin
      cfg_nxt = reg_wdata_i & `GEN_CFG_MASK;
    end
    if (reg_wr_i && reg_addr_i == `OFS_EN) begin
      en_nxt = reg_wdata_i & `EN_MASK;
    end
    if (reg_wr_i && reg_addr_i == `OFS_TOP_EN) begin
      top_en_nxt = reg_wdata_i[0];
    end
  end

  assign cascade = |(sts_r & en_r);
  assign irq_o   = cascade && top_en_r;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd_i) begin
      if (tgt_hit) begin
        unique case (tgt_sub)
          `SUB_TGT_SEC:  rdata_nxt = tgt_r[tgt_ch[0]].sec;
          `SUB_TGT_NS:   rdata_nxt = {2'h0, tgt_r[tgt_ch[0]].ns};
          `SUB_STEP_SEC: rdata_nxt = step_r[tgt_ch[0]].sec;
          `SUB_STEP_NS:  rdata_nxt = {2'h0, step_r[tgt_ch[0]].ns};
        endcase
      end else begin
        case (reg_addr_i)
          `OFS_GEN_CFG:    rdata_nxt = cfg_r;
          `OFS_STS:        rdata_nxt = sts_r;
          `OFS_EN:         rdata_nxt = en_r;
          `OFS_TOP_EN:     rdata_nxt = {31'h0, top_en_r};
          `OFS_TOP_STS:    rdata_nxt = {31'h0, cascade};
          `OFS_CAP_INFO_0: rdata_nxt = {25'h0, tx_cnt_r[0], 1'b0, rx_cnt_r[0]};
          `OFS_CAP_INFO_1: rdata_nxt = {25'h0, tx_cnt_r[1], 1'b0, rx_cnt_r[1]};
          `OFS_CAP_INFO_2: rdata_nxt = {25'h0, tx_cnt_r[2], 1'b0, rx_cnt_r[2]};
          default:         rdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r    <= `REG_RESET;
      sts_r    <= `REG_RESET;
      en_r     <= `REG_RESET;
      top_en_r <= 1'b0;
      rdata_r  <= 32'h00000000;
    end else begin
      cfg_r    <= cfg_nxt;
      sts_r    <= sts_nxt;
      en_r     <= en_nxt;
      top_en_r <= top_en_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_reload_a;
    fire[0] && cfg_r[0] |=> tgt_r[0] == $past(step_r[0]);
  endproperty
  a_reload_a: assert property (p_reload_a)
    else $error("reload did not copy step into target A");

  property p_add_b;
    fire[1] && !cfg_r[1] |=>
      tgt_r[1] == $past(add_val[1]) && tgt_r[1].ns < `NS_PER_SEC;
  endproperty
  a_add_b: assert property (p_add_b)
    else $error("add mode did not step target B");

  property p_sel_write;
    reg_wr_i && reg_addr_i == `OFS_GEN_CFG |=>
      cfg_r[1:0] == $past(reg_wdata_i[1:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("reload select bits not written");

  property p_w1c;
    sts_wr |=> (sts_r & $past(reg_wdata_i & ~sts_set)) == 32'h00000000;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status flag written with one not cleared");

  property p_cascade;
    |(sts_set & en_r) |=> cascade;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("enabled event missing from cascade bit");

  property p_set_any;
    // Sets seen while reset was still applied are not owed to the flags
    rst_b_i |=> (sts_r & $past(sts_set)) == $past(sts_set);
  endproperty
  a_set_any: assert property (p_set_any)
    else $error("event did not set its status flag");

  property p_irq;
    irq_o |-> top_en_r && (sts_r & en_r) != 32'h00000000;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled cascade event");

  property p_manual;
    man_rise[0] && man_fall[7] |=> sts_r[`STS_RISE_LSB] && sts_r[31];
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual capture did not set capture flags");

  property p_timer_keep;
    sts_wr && reg_wdata_i[0] && fire[0] |=> sts_r[0];
  endproperty
  a_timer_keep: assert property (p_timer_keep)
    else $error("timer event lost against a clear");

  property p_gpio_clr;
    (clr_tim & ~fire) != 2'h0 |=>
      (sts_r[1:0] & $past(clr_tim & ~fire)) == 2'h0;
  endproperty
  a_gpio_clr: assert property (p_gpio_clr)
    else $error("gpio clear did not clear timer flag");

  for (genvar g = 0; g < 8; g++) begin : g_pin_chk
    property p_filter;
      filt_r[g] != $past(filt_r[g]) |->
        $past(sync2_r[g], 1) == filt_r[g] && $past(sync2_r[g], 2) == filt_r[g];
    endproperty
    a_filter: assert property (p_filter)
      else $error("capture level accepted before 40 ns");

    property p_rise;
      !filt_r[g] ##1 filt_r[g] |-> sts_r[`STS_RISE_LSB + g];
    endproperty
    a_rise: assert property (p_rise)
      else $error("rising capture flag not set");

    property p_fall;
      filt_r[g] ##1 !filt_r[g] |-> sts_r[`STS_FALL_LSB + g];
    endproperty
    a_fall: assert property (p_fall)
      else $error("falling capture flag not set");
  end

  for (genvar p = 0; p < 3; p++) begin : g_port_chk
    property p_count;
      tx_cnt_r[p] <= `STAMP_MAX && rx_cnt_r[p] <= `STAMP_MAX;
    endproperty
    a_count: assert property (p_count)
      else $error("stamp count above four");

    property p_egress;
      stamp_evt_i.egress[p] && tx_cnt_r[p] < `STAMP_MAX |=>
        sts_r[`STS_TX_LSB + p] && tx_cnt_r[p] != 3'h0;
    endproperty
    a_egress: assert property (p_egress)
      else $error("egress stamp flag not set");

    property p_ingress;
      stamp_evt_i.ingress[p] && rx_cnt_r[p] < `STAMP_MAX |=>
        sts_r[`STS_RX_LSB + p] && rx_cnt_r[p] != 3'h0;
    endproperty
    a_ingress: assert property (p_ingress)
      else $error("ingress stamp flag not set");
  end

endmodule

// ===== tb/tb_ptp_target_event_irq_status.sv
// Self-checking testbench of the timing event status block
`timescale 1ns/1ps
`include "ptp_event_defs.svh"
module tb_ptp_target_event_irq_status;
  logic                      clk_sys_i;
  logic                      rst_b_i;
  logic [11:0]               reg_addr_i;
  logic [31:0]               reg_wdata_i;
  logic                      reg_wr_i;
  logic                      reg_rd_i;
  logic [31:0]               reg_rdata_o;
  ptp_event_pkg::ptp_time_t  now_i;
  logic [7:0]                gpio_i;
  logic [7:0]                gpio_pol_i;
  ptp_event_pkg::stamp_evt_t stamp_evt_i;
  logic                      irq_o;
  integer                    seed = 32'hEE00;
  int                        mismatches;
  int                        n_tests;
  int                        cnt_rx[3];
  int                        cnt_tx[3];
  logic [31:0]               exp_sts;
  logic [31:0]               rv;
  logic [31:0]               tsec;
  logic [31:0]               es;
  logic [31:0]               en;
  logic [11:0]               base;
  logic [11:0]               rst_addr[5];

  ptp_target_event_irq_status dut (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .now_i       (now_i),
    .gpio_i      (gpio_i),
    .gpio_pol_i  (gpio_pol_i),
    .stamp_evt_i (stamp_evt_i),
    .irq_o       (irq_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // Bus tasks and the reference model
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(what, reg_rdata_o, exp);
  endtask

  // Model saturates each counter at four and drops the event there
  task automatic stamp(input logic [5:0] ev);
    @(posedge clk_sys_i);
    stamp_evt_i <= ptp_event_pkg::stamp_evt_t'(ev);
    @(posedge clk_sys_i);
    stamp_evt_i <= 6'h00;
    for (int p = 0; p < 3; p++) begin
      if (ev[p] && cnt_rx[p] < 4) begin
        cnt_rx[p]++;
        exp_sts[8+p] = 1'b1;
      end
      if (ev[3+p] && cnt_tx[p] < 4) begin
        cnt_tx[p]++;
        exp_sts[12+p] = 1'b1;
      end
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_sys_i);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_i     = 1'b0;
    reg_addr_i  = 12'h000;
    reg_wdata_i = 32'h00000000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    now_i       = '0;
    gpio_i      = 8'h00;
    gpio_pol_i  = 8'h04;
    stamp_evt_i = 6'h00;
    exp_sts     = 32'h00000000;
    rst_addr    = '{`OFS_GEN_CFG, `OFS_EN, `OFS_TOP_EN, `OFS_TOP_STS,
                    12'h1FC};
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;

    foreach (rst_addr[i]) rd_chk("reset value", rst_addr[i], 32'h0);
    chk("irq after reset", {31'h0, irq_o}, 32'h00000000);
    // Targets reset to zero with the clock at zero, so both timers fire
    wr(`OFS_STS, 32'h00000003);
    wr(12'h148, 32'h80000000);
    wr(12'h158, 32'h80000000);
    exp_sts = 32'h00000003;
    rd_chk("timer flags", `OFS_STS, exp_sts);
    rd_chk("target step", 12'h140, 32'h80000000);
    wr(`OFS_STS, 32'h00000003);
    exp_sts = 32'h00000000;
    rd_chk("status w1c", `OFS_STS, exp_sts);
    rv = $random(seed);
    wr(`OFS_GEN_CFG, rv);
    rd_chk("config rw", `OFS_GEN_CFG, rv & `GEN_CFG_MASK);
    wr(`OFS_EN, rv);
    rd_chk("enable rw", `OFS_EN, rv & `EN_MASK);
    wr(`OFS_EN, 32'h00000000);
    wr(`OFS_GEN_CFG, 32'h00000000);
    $display("test registers done");

    repeat (5) stamp(6'h01);
    repeat (6) stamp(6'($random(seed)));
    for (int p = 0; p < 3; p++) begin
      rd_chk("stamp count", 12'(`OFS_CAP_INFO_0 + 4 * p),
             32'((cnt_tx[p] << 4) | cnt_rx[p]));
    end
    rd_chk("stamp flags", `OFS_STS, exp_sts);
    wr(`OFS_STS, 32'h00000000);
    rd_chk("zero write", `OFS_STS, exp_sts);
    wr(`OFS_STAMP_POP, 32'h00000011);
    cnt_rx[0]--;
    cnt_tx[0] = (cnt_tx[0] > 0) ? cnt_tx[0] - 1 : 0;
    rd_chk("stamp pop", `OFS_CAP_INFO_0,
           32'((cnt_tx[0] << 4) | cnt_rx[0]));
    // Clear and a fresh event land on the same edge
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= `OFS_STS;
    reg_wdata_i <= 32'h00000100;
    stamp_evt_i <= 6'h01;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
    stamp_evt_i <= 6'h00;
    cnt_rx[0]++;
    rd_chk("set beats clear", `OFS_STS, exp_sts);
    wr(`OFS_STS, 32'hFFFFFFFF);
    exp_sts = 32'h00000000;
    rv = $random(seed) | 32'h00008001;
    wr(`OFS_MAN_CAP, {16'h0000, rv[15:0]});
    exp_sts = {rv[15:8], rv[7:0], 16'h0000};
    rd_chk("manual capture", `OFS_STS, exp_sts);
    wr(`OFS_STS, exp_sts);
    exp_sts = 32'h00000000;
    $display("test stamps done");

    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 2; m++) begin
        base = 12'(12'h140 + 16 * ch);
        tsec = ($random(seed) & 32'h0000FFFF) + 32'h1;
        wr(`OFS_GEN_CFG, 32'(m << ch));
        wr(base + 12'h8, 32'h00000001);
        wr(base + 12'hC, 32'h00000014);
        wr(base, tsec);
        wr(base + 12'h4, 32'h3B9AC9F6);
        @(posedge clk_sys_i);
        now_i <= {tsec, 30'h3B9AC9F6};
        @(posedge clk_sys_i);
        now_i <= '0;
        // Add carries the nanosecond overflow into seconds
        es = m ? 32'h1 : tsec + 32'h2;
        en = m ? 32'h14 : 32'hA;
        exp_sts[ch] = 1'b1;
        rd_chk("target sec", base, es);
        rd_chk("target ns", base + 12'h4, en);
        rd_chk("compare flag", `OFS_STS, exp_sts);
      end
    end
    $display("test compare done");

    wr(`OFS_GEN_CFG, 32'h00000A00);
    @(posedge clk_sys_i);
    gpio_i <= 8'h04;
    @(posedge clk_sys_i);
    gpio_i <= 8'h00;
    repeat (8) @(posedge clk_sys_i);
    rd_chk("short pulse", `OFS_STS, exp_sts);
    gpio_i <= 8'h04;
    repeat (8) @(posedge clk_sys_i);
    exp_sts[18] = 1'b1;
    exp_sts[0]  = 1'b0;
    rd_chk("rise capture", `OFS_STS, exp_sts);
    gpio_i <= 8'h00;
    repeat (8) @(posedge clk_sys_i);
    exp_sts[26] = 1'b1;
    rd_chk("fall capture", `OFS_STS, exp_sts);
    $display("test gpio done");

    wr(`OFS_STS, 32'hFFFFFFFF);
    exp_sts = 32'h00000000;
    stamp(6'h08);
    rd_chk("flag while masked", `OFS_STS, exp_sts);
    rd_chk("cascade masked", `OFS_TOP_STS, 32'h00000000);
    wr(`OFS_EN, 32'h00001000);
    rd_chk("cascade set", `OFS_TOP_STS, 32'h00000001);
    chk("irq top disabled", {31'h0, irq_o}, 32'h00000000);
    wr(`OFS_TOP_EN, 32'h00000001);
    #1;
    chk("irq raised", {31'h0, irq_o}, 32'h00000001);
    wr(`OFS_STS, 32'h00001000);
    #1;
    chk("irq after clear", {31'h0, irq_o}, 32'h00000000);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
